/* rtl/srs_core.sv */
// Fixed one- and two-place shifter for the upper half of the register.
`timescale 1ns/1ps
`default_nettype none
module srs_core
(
    input wire logic [15:0] in_val,
    input wire logic right,
    input wire logic by_two,
    output logic [15:0] out_half
);
    // Vacated places fill with zeros; the lower half never passes through here.
    always_comb
    begin
        if (right)
            out_half = by_two ? {2'b00, in_val[15:2]} : {1'b0, in_val[15:1]};
        else
            out_half = by_two ? {in_val[13:0], 2'b00} : {in_val[14:0], 1'b0};
    end
endmodule
`default_nettype wire

/* rtl/srs_pkg.sv */
// Package of constants and operation codes for the shift and rotate unit.
`default_nettype none
package srs_pkg;
    localparam int WORD_W = 32;
    localparam int HALF_W = 16;
    localparam int CTL_W = 16;
    localparam int CNT_W = 14;
    // Control word bit positions, numbered from the least significant end.
    localparam int CTL_DIR_BIT = 15;
    localparam int CTL_SIZE_BIT = 14;
    localparam int CTL_CNT_MSB = 13;
    localparam logic [31:0] RESULT_RST = 32'h0000_0000;
    typedef enum logic [3:0]
    {
        OP_CIRCULAR_TURN,
        OP_SIGN_KEEPING_SHIFT,
        OP_PLAIN_FULL_SHIFT,
        OP_FULL_LEFT_BY_ONE,
        OP_FULL_LEFT_BY_TWO,
        OP_FULL_RIGHT_BY_ONE,
        OP_FULL_RIGHT_BY_TWO,
        OP_UPPER_LEFT_BY_ONE,
        OP_UPPER_LEFT_BY_TWO,
        OP_UPPER_RIGHT_BY_ONE,
        OP_UPPER_RIGHT_BY_TWO
    } srs_op_t;
endpackage
`default_nettype wire

/* rtl/srs_unit.sv */
// Shift and rotate datapath for a 32-bit general register.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Rotate wraps bits using control word.
// - Only low 16 operand bits control.
// - Bit 1 direction, bit 2 size.
// - Bits 3 to 16 are count.
// - Arithmetic shift keeps the top bit.
// - Plain shift moves every bit.
// - Full left by one.
// - Full left by two.
// - Full right by one.
// - Full right by two.
// - Upper half left by one.
// - Upper half left by two.
// - Upper half right by one.
// - Upper half right by two.
module srs_unit
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic op_valid,
    input wire srs_pkg::srs_op_t op_code,
    input wire logic [31:0] reg_in,
    input wire logic [31:0] operand,
    output logic [31:0] result,
    output logic result_valid
);
    import srs_pkg::*;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rst_s1_reg;
    logic rst_s2_reg;
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    wire logic rst_n = rst_s2_reg;

    // ----------------------------------------
    // Shift functions
    // ----------------------------------------
    // The count is 14 bits wide, so large counts saturate: shifts clear
    // or sign fill, rotates reduce modulo the width.
    // Rotate/shift over width w; rotates and right shifts use double-width arithmetic, left shifts do not.
    function automatic logic [31:0] do_op(input logic [31:0] v, input logic rt,
                                          input logic [1:0] kind, input logic [13:0] n,
                                          input logic half);
        logic [63:0] d;
        logic [31:0] x;
        logic [31:0] mask;
        logic [5:0] w;
        logic [5:0] k;
        logic s;
        w = half ? 6'd16 : 6'd32;
        x = half ? {16'h0000, v[31:16]} : v;
        mask = half ? 32'h0000_FFFF : 32'hFFFF_FFFF;
        s = x[w-1];
        if (kind == 2'd0)
        begin
            k = half ? {2'b00, n[3:0]} : {1'b0, n[4:0]};
            if (rt)
                k = (k == 6'd0) ? 6'd0 : w - k;
            d = {32'h0000_0000, x} << k;
            x = half ? ((d[31:0] | (d[31:0] >> 16)) & mask) : (d[31:0] | d[63:32]);
        end
        else
        begin
            k = (n > 14'd32) ? 6'd32 : n[5:0];
            if (rt)
            begin
                if (kind == 2'd1)
                    x = (x | (s ? ~mask : 32'h0000_0000));
                d = {(kind == 2'd1 && s) ? 32'hFFFF_FFFF : 32'h0000_0000, x};
                d = d >> k;
                x = d[31:0] & mask;
            end
            else
            begin
                x = (x << k) & mask;
                if (kind == 2'd1)
                    x[w-1] = s;
            end
        end
        return half ? {x[15:0], v[15:0]} : x;
    endfunction

    // ----------------------------------------
    // Datapath
    // ----------------------------------------
    logic [15:0] ctl;
    logic [31:0] res_next;
    logic upper_right;
    logic upper_by_two;
    logic [15:0] upper_shifted;
    assign upper_right = op_code == OP_UPPER_RIGHT_BY_ONE || op_code == OP_UPPER_RIGHT_BY_TWO;
    assign upper_by_two = op_code == OP_UPPER_LEFT_BY_TWO || op_code == OP_UPPER_RIGHT_BY_TWO;
    srs_core u_upper
    (
        .in_val(reg_in[31:16]),
        .right(upper_right),
        .by_two(upper_by_two),
        .out_half(upper_shifted)
    );
    always_comb
    begin
        ctl = operand[15:0];
        res_next = reg_in;
        case (op_code)
            OP_CIRCULAR_TURN:
                res_next = do_op(reg_in, ctl[CTL_DIR_BIT], 2'd0, ctl[CTL_CNT_MSB:0],
                                 ctl[CTL_SIZE_BIT]);
            OP_SIGN_KEEPING_SHIFT:
                res_next = do_op(reg_in, ctl[CTL_DIR_BIT], 2'd1, ctl[CTL_CNT_MSB:0],
                                 ctl[CTL_SIZE_BIT]);
            OP_PLAIN_FULL_SHIFT:
                res_next = do_op(reg_in, ctl[CTL_DIR_BIT], 2'd2, ctl[CTL_CNT_MSB:0],
                                 ctl[CTL_SIZE_BIT]);
            OP_FULL_LEFT_BY_ONE: res_next = {reg_in[30:0], 1'b0};
            OP_FULL_LEFT_BY_TWO: res_next = {reg_in[29:0], 2'b00};
            OP_FULL_RIGHT_BY_ONE: res_next = {1'b0, reg_in[31:1]};
            OP_FULL_RIGHT_BY_TWO: res_next = {2'b00, reg_in[31:2]};
            OP_UPPER_LEFT_BY_ONE: res_next = {upper_shifted, reg_in[15:0]};
            OP_UPPER_LEFT_BY_TWO: res_next = {upper_shifted, reg_in[15:0]};
            OP_UPPER_RIGHT_BY_ONE: res_next = {upper_shifted, reg_in[15:0]};
            OP_UPPER_RIGHT_BY_TWO: res_next = {upper_shifted, reg_in[15:0]};
            default: res_next = reg_in;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            result <= RESULT_RST;
            result_valid <= 1'b0;
        end
        else
        begin
            result_valid <= op_valid;
            if (op_valid)
                result <= res_next;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_left_one: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == OP_FULL_LEFT_BY_ONE |=> result == {$past(reg_in[30:0]), 1'b0})
        else $error("left by one wrong");
    a_right_two: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == OP_FULL_RIGHT_BY_TWO |=> result[31:30] == 2'b00)
        else $error("right by two fill wrong");
    a_upper_low_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code >= OP_UPPER_LEFT_BY_ONE |=> result[15:0] == $past(reg_in[15:0]))
        else $error("low half changed");
    a_zero_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code <= OP_PLAIN_FULL_SHIFT && operand[CTL_CNT_MSB:0] == 14'd0
        |=> result == $past(reg_in))
        else $error("zero count changed register");
    a_sign_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == OP_SIGN_KEEPING_SHIFT && !operand[CTL_SIZE_BIT]
        |=> result[31] == $past(reg_in[31]))
        else $error("sign bit changed");
    a_valid_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid |=> result_valid)
        else $error("result valid missing");
    a_upper_r1: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == OP_UPPER_RIGHT_BY_ONE |=> result[31] == 1'b0)
        else $error("upper right fill wrong");
    a_rot_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == OP_CIRCULAR_TURN && !operand[CTL_SIZE_BIT]
        && operand[CTL_CNT_MSB:0] == 14'd32
        |=> result == $past(reg_in))
        else $error("full rotate changed register");
    a_rot_half: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == OP_CIRCULAR_TURN && operand[CTL_SIZE_BIT]
        && operand[CTL_CNT_MSB:0] == 14'd16 |=> result == $past(reg_in))
        else $error("half rotate by sixteen changed register");
    a_left_two: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == OP_FULL_LEFT_BY_TWO |=> result == {$past(reg_in[29:0]), 2'b00})
        else $error("left by two wrong");
    a_right_one: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == OP_FULL_RIGHT_BY_ONE |=> result == {1'b0, $past(reg_in[31:1])})
        else $error("right by one wrong");
    a_right_two_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == OP_FULL_RIGHT_BY_TWO |=> result == {2'b00, $past(reg_in[31:2])})
        else $error("right by two wrong");
    a_upper_l1: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == OP_UPPER_LEFT_BY_ONE
        |=> result[31:16] == {$past(reg_in[30:16]), 1'b0})
        else $error("upper left by one wrong");
    a_upper_l2: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == OP_UPPER_LEFT_BY_TWO
        |=> result[31:16] == {$past(reg_in[29:16]), 2'b00})
        else $error("upper left by two wrong");
    a_upper_r2: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == OP_UPPER_RIGHT_BY_TWO
        |=> result[31:16] == {2'b00, $past(reg_in[31:18])})
        else $error("upper right by two wrong");
    a_plain_left: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == OP_PLAIN_FULL_SHIFT && !operand[CTL_DIR_BIT]
        && !operand[CTL_SIZE_BIT] && operand[CTL_CNT_MSB:0] == 14'd1
        |=> result == {$past(reg_in[30:0]), 1'b0})
        else $error("plain shift lost a bit");
    a_sign_fill: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == OP_SIGN_KEEPING_SHIFT && operand[CTL_DIR_BIT]
        && !operand[CTL_SIZE_BIT] && operand[CTL_CNT_MSB:0] >= 14'd32
        |=> result == {32{$past(reg_in[31])}})
        else $error("arithmetic right fill wrong");
    a_zero_fill: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == OP_PLAIN_FULL_SHIFT
        && !operand[CTL_SIZE_BIT] && operand[CTL_CNT_MSB:0] >= 14'd32
        |=> result == 32'h0000_0000)
        else $error("logical fill wrong");
    sequence s_half_ctl_op;
        op_valid && op_code <= OP_PLAIN_FULL_SHIFT && operand[CTL_SIZE_BIT];
    endsequence
    a_half_ctl_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_half_ctl_op |=> result[15:0] == $past(reg_in[15:0]))
        else $error("half operation changed low half");
    a_result_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !op_valid |=> $stable(result))
        else $error("result moved without an operation");
    a_valid_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !op_valid |=> !result_valid)
        else $error("result valid without an operation");
endmodule
`default_nettype wire

/* tb/srs_unit_tb.sv */
// Self-checking testbench for the shift and rotate unit.
`timescale 1ns/1ps
`default_nettype none
module srs_unit_tb;
    import srs_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic op_valid = 1'b0;
    srs_op_t op_code = OP_CIRCULAR_TURN;
    logic [31:0] reg_in = 32'h0000_0000;
    logic [31:0] operand = 32'h0000_0000;
    logic [31:0] result;
    logic result_valid;
    logic [31:0] exp_q[$];
    int fail_count = 0;
    int n_compared = 0;
    // Counts sit on the width boundaries, where saturation and wrap go wrong.
    int cnt_tab[8] = '{0, 1, 2, 15, 16, 31, 32, 40};
    srs_unit uut
    (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .op_valid(op_valid),
        .op_code(op_code),
        .reg_in(reg_in),
        .operand(operand),
        .result(result),
        .result_valid(result_valid)
    );
    initial
    begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    // ----------------------------------------
    // Reference model
    // ----------------------------------------
    function automatic logic [31:0] model(input srs_op_t op, input logic [31:0] r,
                                          input logic [15:0] c);
        logic [31:0] v, m, o;
        logic signed [63:0] x;
        logic rt, hf, s;
        int w, n, i;
        i = int'(op) - 3;
        rt = (i >= 0) ? i[1] : c[15];
        hf = (i >= 0) ? i[2] : c[14];
        n = (i >= 0) ? i[0] + 1 : int'(c[13:0]);
        w = hf ? 16 : 32;
        m = hf ? 32'h0000_ffff : 32'hffff_ffff;
        v = hf ? {16'h0000, r[31:16]} : r;
        s = v[w-1];
        if (op == OP_CIRCULAR_TURN)
        begin
            n = n % w;
            o = rt ? (v >> n) | (v << (w - n)) : (v << n) | (v >> (w - n));
        end
        else if (op == OP_SIGN_KEEPING_SHIFT && rt)
        begin
            x = hf ? {{48{s}}, v[15:0]} : {{32{s}}, v};
            o = 32'(x >>> (n > w ? w : n));
        end
        else
        begin
            o = (n >= w) ? 32'h0000_0000 : (rt ? v >> n : v << n);
            if (op == OP_SIGN_KEEPING_SHIFT)
                o = (o & (m >> 1)) | (32'(s) << (w - 1));
        end
        o = o & m;
        return hf ? {o[15:0], r[15:0]} : o;
    endfunction
    task automatic check_result(input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("[ERR] result expected %h seen %h", exp, got);
            fail_count++;
        end
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ----------------------------------------
    // Monitor and stimulus
    // ----------------------------------------
    always @(negedge clk_sys)
    begin
        if (result_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
            begin
                $display("[ERR] result_valid expected 0 seen 1");
                fail_count++;
            end
            else
                check_result(exp_q.pop_front(), result);
        end
    end
    initial
    begin
        logic [31:0] r, c;
        logic v;
        void'($urandom(44211));
        repeat (12) @(posedge clk_sys);
        check_result(RESULT_RST, result);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        for (int op = 0; op < 11; op++)
        begin
            for (int k = 0; k < 24; k++)
            begin
                @(posedge clk_sys);
                r = $urandom;
                c = $urandom;
                if (k < 16)
                    c[13:0] = 14'(cnt_tab[k % 8]);
                v = ($urandom % 4) != 0;
                op_valid <= v;
                op_code <= srs_op_t'(op);
                reg_in <= r;
                operand <= c;
                if (v)
                    exp_q.push_back(model(srs_op_t'(op), r, c[15:0]));
            end
        end
        @(posedge clk_sys);
        op_valid <= 1'b0;
        for (int i = 0; i < 20 && exp_q.size() != 0; i++)
            @(posedge clk_sys);
        if (exp_q.size() != 0)
        begin
            $display("[ERR] result_valid expected 1 seen 0");
            fail_count++;
        end
        print_verdict();
    end
endmodule
`default_nettype wire
